//--- rtl/pbdc_device_control.v
`timescale 1ns/1ps
`default_nettype none
`include "pbdc_map.vh"
module pbdc_device_control (
  input wire ref_clk,
  input wire arst_n,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [1:0] cfg_be,
  input wire [15:0] cfg_wdata,
  output reg [15:0] cfg_rdata,
  output reg cfg_rvalid,
  input wire pcix_mode,
  input wire cfg_to_secondary,
  input wire fatal_detect,
  input wire nonfatal_detect,
  input wire corr_detect,
  output reg config_retry_ok,
  output reg [12:0] read_request_limit,
  output reg read_limit_active,
  output reg [9:0] payload_limit,
  output reg msi_no_snoop,
  output reg [`PBDC_TAG_BITS-1:0] tag_mask,
  output reg fatal_message,
  output reg nonfatal_message,
  output reg corr_message,
  output reg [2:0] error_detected
);
  reg [15:0] devctl;
  reg pcix_meta;
  reg pcix_sync;
  wire [15:0] next_devctl;
  wire [15:0] be_mask;
  wire [15:0] devsts;
  wire ctl_hit;
  wire sts_hit;
  wire [2:0] clr;
  wire [2:0] det_flag;
  wire [2:0] msg;
  wire [2:0] rdreq_code;

  assign ctl_hit = cfg_addr == `PBDC_DEVCTL_OFFSET;
  assign sts_hit = cfg_addr == `PBDC_DEVSTS_OFFSET;
  assign be_mask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};
  // only writable bits take data; bits 11:8 and 3 stay zero
  assign next_devctl = (devctl & ~(be_mask & `PBDC_RW_MASK)) | (cfg_wdata & be_mask & `PBDC_RW_MASK);

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      devctl <= `PBDC_RESET_VALUE;
    end else if (cfg_wr && ctl_hit) begin
      devctl <= next_devctl;
    end
  end

  // write-one-to-clear on the status word low byte
  assign clr = (cfg_wr && sts_hit && cfg_be[0]) ? cfg_wdata[2:0] : 3'h0;

  pbdc_err_class u_fatal (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .detect(fatal_detect),
    .report_enable(devctl[`PBDC_BIT_FATAL]),
    .clear(clr[2]),
    .detected(det_flag[2]),
    .message(msg[2])
  );
  pbdc_err_class u_nonfatal (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .detect(nonfatal_detect),
    .report_enable(devctl[`PBDC_BIT_NONFATAL]),
    .clear(clr[1]),
    .detected(det_flag[1]),
    .message(msg[1])
  );
  pbdc_err_class u_corr (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .detect(corr_detect),
    .report_enable(devctl[`PBDC_BIT_CORR]),
    .clear(clr[0]),
    .detected(det_flag[0]),
    .message(msg[0])
  );

  assign devsts = {13'h0000, det_flag};

  // pcix mode pin synchroniser
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pcix_meta <= 1'b0;
      pcix_sync <= 1'b0;
    end else begin
      pcix_meta <= pcix_mode;
      pcix_sync <= pcix_meta;
    end
  end

  assign rdreq_code = (devctl[`PBDC_RDREQ_HI:`PBDC_RDREQ_LO] > `PBDC_RDREQ_MAX) ? `PBDC_RDREQ_MAX
                      : devctl[`PBDC_RDREQ_HI:`PBDC_RDREQ_LO];

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata <= 16'h0000;
      cfg_rvalid <= 1'b0;
      config_retry_ok <= 1'b0;
      read_request_limit <= 13'h0080;
      read_limit_active <= 1'b0;
      payload_limit <= 10'h080;
      msi_no_snoop <= 1'b0;
      tag_mask <= {`PBDC_TAG_BITS{1'b1}};
      fatal_message <= 1'b0;
      nonfatal_message <= 1'b0;
      corr_message <= 1'b0;
      error_detected <= 3'h0;
    end else begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd && ctl_hit) begin
        cfg_rdata <= devctl;
      end else if (cfg_rd && sts_hit) begin
        cfg_rdata <= devsts;
      end else if (cfg_rd) begin
        cfg_rdata <= 16'h0000;
      end
      config_retry_ok <= devctl[`PBDC_BIT_RETRY] & cfg_to_secondary;
      read_request_limit <= 13'h0080 << rdreq_code;
      read_limit_active <= ~pcix_sync;
      payload_limit <= (devctl[`PBDC_PAYLOAD_HI:`PBDC_PAYLOAD_LO] == `PBDC_PAYLOAD_256) ? 10'h100 : 10'h080;
      msi_no_snoop <= 1'b0;
      tag_mask <= {`PBDC_TAG_BITS{1'b1}};
      fatal_message <= msg[2];
      nonfatal_message <= msg[1];
      corr_message <= msg[0];
      error_detected <= det_flag;
    end
  end
endmodule // pbdc_device_control
`default_nettype wire

//--- rtl/pbdc_map.vh
`ifndef PBDC_MAP_VH
`define PBDC_MAP_VH
`define PBDC_DEVCTL_OFFSET 8'h4C
`define PBDC_DEVSTS_OFFSET 8'h4E
`define PBDC_RESET_VALUE 16'h2000
`define PBDC_RW_MASK 16'hF0F7
`define PBDC_BIT_RETRY 15
`define PBDC_RDREQ_HI 14
`define PBDC_RDREQ_LO 12
`define PBDC_PAYLOAD_HI 7
`define PBDC_PAYLOAD_LO 5
`define PBDC_BIT_RSVD4 4
`define PBDC_BIT_FATAL 2
`define PBDC_BIT_NONFATAL 1
`define PBDC_BIT_CORR 0
`define PBDC_RDREQ_MAX 3'h5
`define PBDC_PAYLOAD_256 3'h1
`define PBDC_TAG_BITS 5
`endif

//--- rtl/pbdc_err_class.v
`timescale 1ns/1ps
`default_nettype none
// one error class: sticky detect flag, gated message pulse
module pbdc_err_class (
  input wire ref_clk,
  input wire arst_n,
  input wire detect,
  input wire report_enable,
  input wire clear,
  output reg detected,
  output reg message
);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      detected <= 1'b0;
      message <= 1'b0;
    end else begin
      // set wins over clear
      detected <= detect | (detected & ~clear);
      message <= detect & report_enable;
    end
  end
endmodule // pbdc_err_class
`default_nettype wire

//--- sim/pbdc_host.sv
`timescale 1ns/1ps
`default_nettype none
module pbdc_host (
  input wire logic ref_clk,
  output logic cfg_wr = 0,
  output logic cfg_rd = 0,
  output logic [7:0] cfg_addr = 8'h00,
  output logic [1:0] cfg_be = 2'h3,
  output logic [15:0] cfg_wdata = 16'h0000
);
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
    @(negedge ref_clk);
    {cfg_wr, cfg_rd, cfg_wdata} = {2'h0, ~d};
  endtask
endmodule // pbdc_host
`default_nettype wire

//--- sim/pbdc_props.sv
`timescale 1ns/1ps
`default_nettype none
module pbdc_props (
  input wire ref_clk,
  input wire arst_n,
  input wire cfg_to_secondary,
  input wire config_retry_ok,
  input wire [12:0] read_request_limit,
  input wire msi_no_snoop,
  input wire [4:0] tag_mask,
  input wire [9:0] payload_limit,
  input wire cfg_rvalid,
  input wire [15:0] cfg_rdata,
  input wire fatal_detect,
  input wire fatal_message,
  input wire [2:0] error_detected
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_RETRY: assert property (config_retry_ok |-> $past(cfg_to_secondary)) else $error("bad retry");
  AST_RRL: assert property ($onehot(read_request_limit) && read_request_limit >= 13'h80) else $error("bad read limit");
  AST_SNOOP: assert property (!msi_no_snoop) else $error("no snoop set");
  AST_TAG: assert property (tag_mask == 5'h1F) else $error("bad tag");
  AST_PAY: assert property (payload_limit == 10'h80 || payload_limit == 10'h100) else $error("bad payload");
  AST_RO: assert property (cfg_rvalid |-> cfg_rdata[11:8] == 4'h0 && !cfg_rdata[3]) else $error("ro set");
  AST_MSG: assert property (fatal_message |-> $past(fatal_detect, 2)) else $error("bad msg");
  AST_FLAG: assert property (fatal_detect |-> ##2 error_detected[2]) else $error("no flag");
endmodule // pbdc_props
`default_nettype wire

//--- sim/pbdc_device_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module pbdc_device_control_test;
  logic ref_clk = 0, arst_n = 0, pcix_mode, cfg_to_secondary, fatal_detect = 0, nonfatal_detect = 0, corr_detect = 0;
  wire cfg_wr, cfg_rd, cfg_rvalid, config_retry_ok, read_limit_active, msi_no_snoop;
  wire fatal_message, nonfatal_message, corr_message;
  wire [7:0] cfg_addr;
  wire [1:0] cfg_be;
  wire [15:0] cfg_wdata, cfg_rdata;
  wire [12:0] read_request_limit;
  wire [9:0] payload_limit;
  wire [4:0] tag_mask;
  wire [2:0] error_detected;
  logic [15:0] q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  pbdc_host host (.*);
  pbdc_device_control uut (.*);
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    q.push_back(e);
    host.acc(0, a, 16'h0000);
  endtask
  always @(negedge ref_clk) begin
    cyc++;
    if (cfg_rvalid === 1'b1) chk("rdata", q.pop_front(), cfg_rdata);
    if (cyc > 2000) begin
      error_cnt++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(32'h164D5FAF));
    {pcix_mode, cfg_to_secondary} = 2'($urandom);
    repeat (3) @(negedge ref_clk);
    arst_n = 1;
    rd(8'h4C, 16'h2000);
    host.acc(1, 8'h4C, 16'hFFFF);
    rd(8'h4C, 16'hF0F7);
    rd(8'h40, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      pcix_mode = pcix_mode ^ 1'($urandom);
      host.acc(1, 8'h4C, 16'(c << 12) | 16'(c << 5));
      repeat (2) @(negedge ref_clk);
      chk("read_request_limit", 16'(13'h80 << (c > 5 ? 5 : c)), {3'h0, read_request_limit});
      chk("payload_limit", c == 1 ? 16'h0100 : 16'h0080, {6'h0, payload_limit});
      chk("act", {15'h0, !pcix_mode}, {15'h0, read_limit_active});
    end
    {fatal_detect, nonfatal_detect, corr_detect} = 3'h7;
    @(negedge ref_clk);
    {fatal_detect, nonfatal_detect, corr_detect} = 3'h0;
    @(negedge ref_clk);
    chk("messages_off", 16'h0000, {13'h0, fatal_message, nonfatal_message, corr_message});
    chk("error_detected", 16'h0007, {13'h0, error_detected});
    rd(8'h4E, 16'h0007);
    host.acc(1, 8'h4C, 16'h0007);
    {fatal_detect, nonfatal_detect, corr_detect} = 3'h7;
    @(negedge ref_clk);
    {fatal_detect, nonfatal_detect, corr_detect} = 3'h0;
    @(negedge ref_clk);
    chk("messages_on", 16'h0007, {13'h0, fatal_message, nonfatal_message, corr_message});
    @(negedge ref_clk);
    chk("messages_end", 16'h0000, {13'h0, fatal_message, nonfatal_message, corr_message});
    host.acc(1, 8'h4E, 16'h0007);
    rd(8'h4E, 16'h0000);
    repeat (3) @(negedge ref_clk);
    wrap_up;
  end
endmodule // pbdc_device_control_test
bind pbdc_device_control pbdc_props chk (.*);
`default_nettype wire
